// ### design/btp_consts.svh
// Purpose: Shared numbers for the backplane trigger line logic.
// Assumes: One 100 MHz clock; trigger levels are asserted-high inside.
// Notes: Cycle counts are derived from the printed times and the period.
`ifndef BTP_CONSTS_SVH
`define BTP_CONSTS_SVH

`define BTP_CLK_PERIOD_NS 10
`define BTP_SYNC_HIGH_NS 30
`define BTP_SYNC_GAP_NS 50
`define BTP_SEMI_PULSE_NS 50
`define BTP_SEMI_ACC_NS 40
`define BTP_NUM_TTL 8
`define BTP_NUM_ECL 2
`define BTP_SETTLE_CYC 3

`define BTP_CEIL_CYC(ns) (((ns) + `BTP_CLK_PERIOD_NS - 1) / `BTP_CLK_PERIOD_NS)
`define BTP_SYNC_HIGH_CYC `BTP_CEIL_CYC(`BTP_SYNC_HIGH_NS)
`define BTP_SYNC_GAP_CYC `BTP_CEIL_CYC(`BTP_SYNC_GAP_NS)
`define BTP_SEMI_PULSE_CYC `BTP_CEIL_CYC(`BTP_SEMI_PULSE_NS)

`endif

// ### design/btp_pkg.sv
// Purpose: Types for the backplane trigger line logic.
// Assumes: Included numbers come from btp_consts.svh.
// Notes: Modes and routing are per line.
package btp_pkg;

  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_SYNC_SRC,
    MODE_SYNC_ACC,
    MODE_SEMI_SRC,
    MODE_SEMI_ACC,
    MODE_ASYNC_SRC,
    MODE_ASYNC_ACC,
    MODE_STARTSTOP
  } btp_mode_t;

  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_FROM_FRONT,
    ROUTE_TO_FRONT,
    ROUTE_RSVD
  } btp_route_t;

  typedef enum logic {
    CLK_DRIVE_OUT,
    CLK_RECEIVE
  } btp_clk_mode_t;

  typedef enum {
    ST_IDLE,
    ST_PULSE,
    ST_GAP,
    ST_WAIT_LOW,
    ST_PEND,
    ST_HOLD
  } btp_state_t;

  typedef logic [3:0] btp_cnt_t;

  typedef struct packed {
    btp_mode_t mode;
    btp_route_t route;
    logic accRising;
    logic irqRiseEn;
    logic irqFallEn;
  } btp_line_cfg_t;

  typedef struct packed {
    logic riseFlag;
    logic fallFlag;
    logic doneFlag;
    logic busy;
    logic irqReq;
    logic acceptPulse;
  } btp_line_stat_t;

endpackage

// ### design/btp_edge.sv
// Purpose: Synchronise one input, detect its edges, hold sticky flags.
// Assumes: Clear inputs are one-cycle pulses from the clock domain.
// Notes: A set in the same cycle as a clear wins, so no edge is lost.
`timescale 1ns/1ps
module btp_edge (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Raw input and flag clears
  input wire logic rawIn,
  input wire logic clearRise,
  input wire logic clearFall,
  // Results
  output logic level,
  output logic risePulse,
  output logic fallPulse,
  output logic riseFlag,
  output logic fallFlag
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic rise_q;
  logic fall_q;
  logic riseFlag_q;
  logic fallFlag_q;
  wire logic riseNow = sync_q & ~prev_q;
  wire logic fallNow = ~sync_q & prev_q;

  // The first stage feeds only the second; edges look at later stages.
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= rawIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      riseFlag_q <= 1'b0;
      fallFlag_q <= 1'b0;
    end else begin
      rise_q <= riseNow;
      fall_q <= fallNow;
      riseFlag_q <= riseNow | (riseFlag_q & ~clearRise);
      fallFlag_q <= fallNow | (fallFlag_q & ~clearFall);
    end
  end

  assign level = prev_q;
  assign risePulse = rise_q;
  assign fallPulse = fall_q;
  assign riseFlag = riseFlag_q;
  assign fallFlag = fallFlag_q;
endmodule

// ### design/btp_top.sv
// Purpose: Trigger line routing, protocol engines and reference clock path.
// Assumes: Backplane lines are wired-OR; asserted is 1 on these ports.
// Notes: Line i pairs with line i^1 for the asynchronous protocol.
`timescale 1ns/1ps
`include "btp_consts.svh"
module btp_top
  import btp_pkg::*;
#(
  parameter int NUM_TTL = `BTP_NUM_TTL,
  parameter int NUM_ECL = `BTP_NUM_ECL
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // TTL backplane trigger lines
  input wire logic [NUM_TTL-1:0] ttlTrigIn,
  output logic [NUM_TTL-1:0] ttlTrigOut,
  output logic [NUM_TTL-1:0] ttlTrigOe,
  // ECL backplane trigger lines
  input wire logic [NUM_ECL-1:0] eclTrigIn,
  output logic [NUM_ECL-1:0] eclTrigOut,
  output logic [NUM_ECL-1:0] eclTrigOe,
  // Front panel trigger connectors
  input wire logic front_trigger_input,
  output logic front_trigger_output,
  // Reference clock paths
  input wire btp_clk_mode_t clkMode,
  input wire logic clk10RefIn,
  output logic clk10RefOut,
  output logic clk10RefOe,
  input wire logic front_external_clock_in,
  output logic front_external_clock_out,
  output logic front_external_clock_oe,
  // Per-line configuration and commands
  input wire btp_line_cfg_t [NUM_TTL+NUM_ECL-1:0] lineCfg,
  input wire logic [NUM_TTL+NUM_ECL-1:0] fire,
  input wire logic [NUM_TTL+NUM_ECL-1:0] ready,
  input wire logic [NUM_TTL+NUM_ECL-1:0] runLevel,
  input wire logic [NUM_TTL+NUM_ECL-1:0] clearRise,
  input wire logic [NUM_TTL+NUM_ECL-1:0] clearFall,
  input wire logic [NUM_TTL+NUM_ECL-1:0] clearDone,
  // Per-line status
  output btp_line_stat_t [NUM_TTL+NUM_ECL-1:0] lineStat
);
  localparam int NL = NUM_TTL + NUM_ECL;
  localparam btp_cnt_t SyncHighCyc = btp_cnt_t'(`BTP_SYNC_HIGH_CYC);
  localparam btp_cnt_t SyncGapCyc = btp_cnt_t'(`BTP_SYNC_GAP_CYC);
  localparam btp_cnt_t SemiPulseCyc = btp_cnt_t'(`BTP_SEMI_PULSE_CYC);
  localparam btp_cnt_t SettleCyc = btp_cnt_t'(`BTP_SETTLE_CYC);

  // All lines side by side; ECL lines sit above the TTL lines.
  wire logic [NL-1:0] lineRaw = {eclTrigIn, ttlTrigIn};
  logic [NL-1:0] lineLvl;
  logic [NL-1:0] lineRise;
  logic [NL-1:0] lineFall;
  logic [NL-1:0] lineRiseFlag;
  logic [NL-1:0] lineFallFlag;
  logic [NL-1:0] drive_q;
  logic [NL-1:0] toFrontMask;

  logic frontTrigLvl;
  logic frontClkLvl;
  logic refClkLvl;
  logic refClkRise;
  logic frontClkRise;
  logic frontTrigOut_q;
  logic clkOut_q;
  logic clkOe_q;
  logic extOut_q;
  logic extOe_q;

  // Front trigger input is synchronised once and shared by every line.
  btp_edge uFrontTrig (
    .clock(clock),
    .srst(srst),
    .rawIn(front_trigger_input),
    .clearRise(1'b0),
    .clearFall(1'b0),
    .level(frontTrigLvl),
    .risePulse(),
    .fallPulse(),
    .riseFlag(),
    .fallFlag()
  );

  btp_edge uRefClk (
    .clock(clock),
    .srst(srst),
    .rawIn(clk10RefIn),
    .clearRise(1'b0),
    .clearFall(1'b0),
    .level(refClkLvl),
    .risePulse(refClkRise),
    .fallPulse(),
    .riseFlag(),
    .fallFlag()
  );

  btp_edge uFrontClk (
    .clock(clock),
    .srst(srst),
    .rawIn(front_external_clock_in),
    .clearRise(1'b0),
    .clearFall(1'b0),
    .level(frontClkLvl),
    .risePulse(frontClkRise),
    .fallPulse(),
    .riseFlag(),
    .fallFlag()
  );

  // The start/stop tick follows whichever reference this frame runs on.
  wire logic clkTick = (clkMode == CLK_RECEIVE) ? frontClkRise : refClkRise;

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : gLine
      localparam int PI = ((gi ^ 1) < NL) ? (gi ^ 1) : gi;
      btp_state_t st_q;
      btp_state_t st_d;
      btp_cnt_t cnt_q;
      btp_cnt_t cnt_d;
      logic srcDrv_q;
      logic srcDrv_d;
      logic done_q;
      logic doneSet;
      logic accept_q;
      logic acceptNow;
      logic irq_q;
      logic busy_q;
      wire btp_line_cfg_t cfg = lineCfg[gi];
      wire logic partnerLvl = lineLvl[PI];
      wire logic partnerRise = lineRise[PI];
      wire logic fromFront = (cfg.route == ROUTE_FROM_FRONT);
      wire logic drive_d = fromFront ? frontTrigLvl : srcDrv_d;
      wire logic irq_d = (lineRiseFlag[gi] & cfg.irqRiseEn) |
                         (lineFallFlag[gi] & cfg.irqFallEn);
      wire logic syncEdge = cfg.accRising ? lineRise[gi] : lineFall[gi];

      btp_edge uEdge (
        .clock(clock),
        .srst(srst),
        .rawIn(lineRaw[gi]),
        .clearRise(clearRise[gi]),
        .clearFall(clearFall[gi]),
        .level(lineLvl[gi]),
        .risePulse(lineRise[gi]),
        .fallPulse(lineFall[gi]),
        .riseFlag(lineRiseFlag[gi]),
        .fallFlag(lineFallFlag[gi])
      );

      assign toFrontMask[gi] = (cfg.route == ROUTE_TO_FRONT);

      always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        srcDrv_d = srcDrv_q;
        doneSet = 1'b0;
        acceptNow = 1'b0;
        case (st_q)
          ST_IDLE: begin
            srcDrv_d = 1'b0;
            if (cfg.mode == MODE_SYNC_SRC && fire[gi]) begin
              st_d = ST_PULSE;
              cnt_d = btp_cnt_t'(SyncHighCyc - 1'b1);
              srcDrv_d = 1'b1;
            end else if (cfg.mode == MODE_SEMI_SRC && fire[gi]) begin
              st_d = ST_PULSE;
              cnt_d = btp_cnt_t'(SemiPulseCyc - 1'b1);
              srcDrv_d = 1'b1;
            end else if (cfg.mode == MODE_SEMI_ACC && lineRise[gi]) begin
              st_d = ST_HOLD;
              srcDrv_d = 1'b1;
              acceptNow = 1'b1;
            end else if (cfg.mode == MODE_ASYNC_SRC && fire[gi] &&
                         !partnerLvl) begin
              st_d = ST_HOLD;
              srcDrv_d = 1'b1;
            end else if (cfg.mode == MODE_ASYNC_ACC && partnerRise) begin
              st_d = ST_PEND;
              acceptNow = 1'b1;
            end else if (cfg.mode == MODE_SYNC_ACC && syncEdge) begin
              acceptNow = 1'b1;
            end else if (cfg.mode == MODE_STARTSTOP) begin
              srcDrv_d = clkTick ? runLevel[gi] : srcDrv_q;
            end
          end
          ST_PULSE: begin
            if (cnt_q != '0) begin
              cnt_d = btp_cnt_t'(cnt_q - 1'b1);
            end else if (cfg.mode == MODE_SYNC_SRC) begin
              st_d = ST_GAP;
              cnt_d = btp_cnt_t'(SyncGapCyc - 1'b1);
              srcDrv_d = 1'b0;
            end else begin
              st_d = ST_WAIT_LOW;
              cnt_d = SettleCyc;
              srcDrv_d = 1'b0;
            end
          end
          ST_GAP: begin
            if (cnt_q != '0) begin
              cnt_d = btp_cnt_t'(cnt_q - 1'b1);
            end else begin
              st_d = ST_IDLE;
              doneSet = 1'b1;
            end
          end
          ST_WAIT_LOW: begin
            // Our own release needs the synchroniser delay to be seen.
            if (cnt_q != '0) begin
              cnt_d = btp_cnt_t'(cnt_q - 1'b1);
            end else if (!lineLvl[gi]) begin
              st_d = ST_IDLE;
              doneSet = 1'b1;
            end
          end
          ST_PEND: begin
            if (ready[gi]) begin
              st_d = ST_HOLD;
              srcDrv_d = 1'b1;
            end
          end
          ST_HOLD: begin
            if (cfg.mode == MODE_SEMI_ACC && ready[gi]) begin
              st_d = ST_IDLE;
              srcDrv_d = 1'b0;
              doneSet = 1'b1;
            end else if (cfg.mode == MODE_ASYNC_SRC && partnerLvl) begin
              st_d = ST_IDLE;
              srcDrv_d = 1'b0;
              doneSet = 1'b1;
            end else if (cfg.mode == MODE_ASYNC_ACC && !partnerLvl) begin
              st_d = ST_IDLE;
              srcDrv_d = 1'b0;
              doneSet = 1'b1;
            end else if (cfg.mode != MODE_SEMI_ACC &&
                         cfg.mode != MODE_ASYNC_SRC &&
                         cfg.mode != MODE_ASYNC_ACC) begin
              st_d = ST_IDLE;
              srcDrv_d = 1'b0;
            end
          end
          default: begin
            st_d = ST_IDLE;
            srcDrv_d = 1'b0;
          end
        endcase
        if (cfg.mode == MODE_OFF) begin
          st_d = ST_IDLE;
          srcDrv_d = 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          st_q <= ST_IDLE;
          cnt_q <= '0;
          srcDrv_q <= 1'b0;
          drive_q[gi] <= 1'b0;
        end else begin
          st_q <= st_d;
          cnt_q <= cnt_d;
          srcDrv_q <= srcDrv_d;
          drive_q[gi] <= drive_d;
        end
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          done_q <= 1'b0;
          accept_q <= 1'b0;
          irq_q <= 1'b0;
          busy_q <= 1'b0;
        end else begin
          done_q <= doneSet | (done_q & ~clearDone[gi]);
          accept_q <= acceptNow;
          irq_q <= irq_d;
          busy_q <= (st_d != ST_IDLE);
        end
      end

      assign lineStat[gi].riseFlag = lineRiseFlag[gi];
      assign lineStat[gi].fallFlag = lineFallFlag[gi];
      assign lineStat[gi].doneFlag = done_q;
      assign lineStat[gi].busy = busy_q;
      assign lineStat[gi].irqReq = irq_q;
      assign lineStat[gi].acceptPulse = accept_q;
    end
  endgenerate

  // Open-collector style: a line is only driven while asserted.
  assign ttlTrigOut = drive_q[NUM_TTL-1:0];
  assign ttlTrigOe = drive_q[NUM_TTL-1:0];
  assign eclTrigOut = drive_q[NL-1:NUM_TTL];
  assign eclTrigOe = drive_q[NL-1:NUM_TTL];

  // Lines we drive ourselves also reach the front output via the pins.
  wire logic frontOut_d = |(lineLvl & toFrontMask);

  always_ff @(posedge clock) begin
    if (srst) begin
      frontTrigOut_q <= 1'b0;
      clkOut_q <= 1'b0;
      clkOe_q <= 1'b0;
      extOut_q <= 1'b0;
      extOe_q <= 1'b0;
    end else begin
      frontTrigOut_q <= frontOut_d;
      clkOut_q <= frontClkLvl;
      clkOe_q <= (clkMode == CLK_RECEIVE);
      extOut_q <= refClkLvl;
      extOe_q <= (clkMode == CLK_DRIVE_OUT);
    end
  end

  assign front_trigger_output = frontTrigOut_q;
  assign clk10RefOut = clkOut_q;
  assign clk10RefOe = clkOe_q;
  assign front_external_clock_out = extOut_q;
  assign front_external_clock_oe = extOe_q;
endmodule

// ### tb/btp_far_model.sv
// Purpose: Far-side modules sharing the backplane trigger lines.
// Assumes: Undriven lines rest unasserted through their terminations.
// Notes: Line 2 semi acceptor, 3 semi source, 5 async acceptor, 8 bench.
`timescale 1ns/1ps
module btp_far_model (
  // Clock
  input wire logic clock,
  // Device drive and bench commands
  input wire logic [9:0] oe,
  input wire logic semiGo,
  input wire logic syncDrv,
  input wire logic [7:0] holdCyc,
  input wire logic [7:0] ackDly,
  // Wired-OR line levels
  output logic [9:0] lvl
);
  logic prev2 = 1'b0;
  logic ack5 = 1'b0;
  logic [7:0] accCnt = 8'h00;
  logic [7:0] srcCnt = 8'h00;
  logic [7:0] ackCnt = 8'h00;
  wire logic acc2 = accCnt != 8'h00;
  wire logic src3 = srcCnt != 8'h00;
  // A released line falls to its idle level, never the last driven value.
  assign lvl = oe | {1'b0, syncDrv, 2'b00, ack5, 1'b0, src3, acc2, 2'b00};
  always @(posedge clock) begin
    prev2 <= oe[2];
    if (oe[2] && !prev2) begin
      accCnt <= holdCyc;
    end else if (acc2) begin
      accCnt <= accCnt - 8'h01;
    end
    srcCnt <= semiGo ? 8'h05 : (src3 ? srcCnt - 8'h01 : 8'h00);
    ackCnt <= oe[4] ? ackCnt + 8'h01 : 8'h00;
    ack5 <= oe[4] && ackCnt >= ackDly;
  end
endmodule

// ### tb/btp_top_assertions.sv
// Purpose: Port-level checks of trigger pulse shapes and handshakes.
// Assumes: Lines 0, 2, 3, 4 and 8 keep the modes the bench gives them.
// Notes: Widths are the rounded-up cycle counts at 100 MHz.
`timescale 1ns/1ps
module btp_top_assertions
  import btp_pkg::*;
#(
  parameter int NUM_TTL = 8,
  parameter int NUM_ECL = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Trigger lines
  input wire logic [NUM_TTL-1:0] ttlTrigIn,
  input wire logic [NUM_TTL-1:0] ttlTrigOe,
  input wire logic [NUM_ECL-1:0] eclTrigIn,
  input wire logic [NUM_ECL-1:0] eclTrigOe,
  // Clock path and line control
  input wire btp_clk_mode_t clkMode,
  input wire logic clk10RefOe,
  input wire logic front_external_clock_oe,
  input wire btp_line_cfg_t [NUM_TTL+NUM_ECL-1:0] lineCfg,
  input wire logic [NUM_TTL+NUM_ECL-1:0] ready,
  input wire logic [NUM_TTL+NUM_ECL-1:0] clearRise,
  input wire btp_line_stat_t [NUM_TTL+NUM_ECL-1:0] lineStat
);
  wire logic [NUM_TTL+NUM_ECL-1:0] oe = {eclTrigOe, ttlTrigOe};
  wire logic [NUM_TTL+NUM_ECL-1:0] lvl = {eclTrigIn, ttlTrigIn};
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_sync_high;
    $rose(oe[0]) && lineCfg[0].mode == MODE_SYNC_SRC
      |-> oe[0] [*3] ##1 !oe[0];
  endproperty
  a_sync_high: assert property (p_sync_high)
    else $error("sync source pulse width wrong");
  property p_sync_gap;
    $fell(oe[0]) && lineCfg[0].mode == MODE_SYNC_SRC |-> !oe[0] [*5];
  endproperty
  a_sync_gap: assert property (p_sync_gap)
    else $error("sync source gap too short");
  property p_semi_pulse;
    $rose(oe[2]) && lineCfg[2].mode == MODE_SEMI_SRC |-> oe[2] [*5];
  endproperty
  a_semi_pulse: assert property (p_semi_pulse)
    else $error("semi source pulse too short");
  property p_clk_dir;
    !$past(srst) |-> clk10RefOe == ($past(clkMode) == CLK_RECEIVE)
      && front_external_clock_oe != clk10RefOe;
  endproperty
  a_clk_dir: assert property (p_clk_dir)
    else $error("reference clock direction wrong");
  property p_irq;
    $rose(lineStat[8].riseFlag) && lineCfg[8].irqRiseEn
      |=> lineStat[8].irqReq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("edge request missing");
  property p_sticky;
    lineStat[8].riseFlag && !clearRise[8] |=> lineStat[8].riseFlag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("edge flag lost without clear");
  property p_semi_join;
    $rose(lvl[3]) && !oe[3] && lineCfg[3].mode == MODE_SEMI_ACC
      |-> ##[1:4] oe[3];
  endproperty
  a_semi_join: assert property (p_semi_join)
    else $error("semi acceptor did not join");
  property p_semi_hold;
    oe[3] && !ready[3] && !$past(ready[3])
      && lineCfg[3].mode == MODE_SEMI_ACC |=> oe[3];
  endproperty
  a_semi_hold: assert property (p_semi_hold)
    else $error("semi acceptor released early");
  property p_async_rel;
    $fell(oe[4]) && lineCfg[4].mode == MODE_ASYNC_SRC |-> $past(lvl[5], 3);
  endproperty
  a_async_rel: assert property (p_async_rel)
    else $error("async source released before acknowledge");
  c_sync: cover property (lineStat[0].doneFlag);
  c_semi_acc: cover property ($rose(oe[3]));
  c_async: cover property ($fell(oe[4]));
endmodule

bind btp_top btp_top_assertions #(
  .NUM_TTL(NUM_TTL),
  .NUM_ECL(NUM_ECL)
) btp_top_assertions_i (
  .clock(clock), .srst(srst),
  .ttlTrigIn(ttlTrigIn), .ttlTrigOe(ttlTrigOe),
  .eclTrigIn(eclTrigIn), .eclTrigOe(eclTrigOe),
  .clkMode(clkMode), .clk10RefOe(clk10RefOe),
  .front_external_clock_oe(front_external_clock_oe),
  .lineCfg(lineCfg), .ready(ready), .clearRise(clearRise),
  .lineStat(lineStat)
);

// ### tb/backplane_trigger_protocols_bench.sv
// Purpose: Random and corner runs of the trigger line block.
// Assumes: Each line but line 9 keeps one mode; the far model shares the lines.
// Notes: Expected widths come from the shared cycle macros.
`timescale 1ns/1ps
`include "btp_consts.svh"
module backplane_trigger_protocols_bench
  import btp_pkg::*;
;
  logic clock, srst, frontIn, frontOut;
  logic frontSeen = 1'b0;
  logic refIn = 1'b0;
  logic extIn = 1'b0;
  logic refOe, extOe, semiGo, syncDrv, refOut, extOut;
  logic [9:0] lvl, fire, ready, runLevel, clrR, clrF, clrD;
  logic [7:0] ttlOut, ttlOe, holdCyc, ackDly;
  logic [1:0] eclOut, eclOe;
  wire logic [9:0] oe = {eclOe, ttlOe};
  btp_clk_mode_t clkMode;
  btp_line_cfg_t [9:0] cfg;
  btp_line_stat_t [9:0] st;
  int miscompares = 0;
  int cmp_count = 0;
  int refCnt = 0;
  int acc = 0;
  int n, k, m, a0, hold;
  int run[10] = '{default: 0};
  int len[10] = '{default: 0};
  int rises[10] = '{default: 0};
  btp_top btp_top_i (
    .clock(clock), .srst(srst),
    .ttlTrigIn(lvl[7:0]), .ttlTrigOut(ttlOut), .ttlTrigOe(ttlOe),
    .eclTrigIn(lvl[9:8]), .eclTrigOut(eclOut), .eclTrigOe(eclOe),
    .front_trigger_input(frontIn), .front_trigger_output(frontOut),
    .clkMode(clkMode), .clk10RefIn(refIn), .clk10RefOut(refOut),
    .clk10RefOe(refOe), .front_external_clock_in(extIn),
    .front_external_clock_out(extOut), .front_external_clock_oe(extOe),
    .lineCfg(cfg), .fire(fire), .ready(ready), .runLevel(runLevel),
    .clearRise(clrR), .clearFall(clrF), .clearDone(clrD), .lineStat(st)
  );
  btp_far_model btp_far_model_i (
    .clock(clock), .oe(oe), .semiGo(semiGo), .syncDrv(syncDrv),
    .holdCyc(holdCyc), .ackDly(ackDly), .lvl(lvl)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Pulse lengths are measured here so scenarios only read finished runs.
  always @(posedge clock) begin
    refCnt <= (refCnt == 9) ? 0 : refCnt + 1;
    refIn <= refCnt < 5;
    extIn <= refCnt > 2;
    if (frontOut) frontSeen = 1'b1;
    if (st[8].acceptPulse) acc++;
    for (int i = 0; i < 10; i++) begin
      if (oe[i]) begin
        run[i]++;
      end else if (run[i] != 0) begin
        len[i] = run[i];
        run[i] = 0;
        rises[i]++;
      end
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic go(input int i);
    fire <= 10'h001 << i;
    tick(1);
    fire <= 10'h000;
  endtask
  task automatic clr(input int i);
    {clrR, clrF, clrD} <= {3{10'h001 << i}};
    tick(1);
    {clrR, clrF, clrD} <= 30'h0;
  endtask
  task automatic waitDone(input int i, input int lim);
    for (n = 0; n < lim && st[i].doneFlag !== 1'b1; n++) tick(1);
  endtask
  task automatic waitOe(input int i, input logic v);
    for (n = 0; n < 30 && oe[i] !== v; n++) tick(1);
    chk(oe[i], v);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    tick(20000);
    miscompares++;
    wrap_up;
  end
  initial begin
    void'($urandom(45));
    srst = 1'b1;
    {fire, ready, runLevel, clrR, clrF, clrD} = 60'h0;
    {frontIn, semiGo, syncDrv} = 3'h0;
    holdCyc = 8'h06;
    ackDly = 8'h01;
    clkMode = CLK_DRIVE_OUT;
    cfg = '0;
    cfg[0] = '{MODE_SYNC_SRC, ROUTE_TO_FRONT, 1'b0, 1'b0, 1'b0};
    cfg[2].mode = MODE_SEMI_SRC;
    cfg[3].mode = MODE_SEMI_ACC;
    cfg[4].mode = MODE_ASYNC_SRC;
    cfg[6].mode = MODE_STARTSTOP;
    cfg[8] = '{MODE_SYNC_ACC, ROUTE_NONE, 1'b1, 1'b1, 1'b1};
    cfg[9].route = ROUTE_FROM_FRONT;
    tick(12);
    srst <= 1'b0;
    tick(1);
    // The second fire lands while busy and has to be dropped.
    for (k = 0; k < 3; k++) begin
      go(0);
      tick(1);
      chk(st[0].busy, 1'b1);
      go(0);
      waitDone(0, 40);
      chk(16'(len[0]), 16'(`BTP_SYNC_HIGH_CYC));
      chk(16'(rises[0]), 16'(k + 1));
      chk({eclOut, ttlOut}, oe);
      clr(0);
      tick($urandom_range(0, 3));
    end
    chk(frontSeen, 1'b1);
    go(1);
    tick(3);
    chk(oe[1], 1'b0);
    for (k = 0; k < 3; k++) begin
      hold = (k == 0) ? 6 : $urandom_range(8, 30);
      holdCyc <= 8'(hold);
      go(2);
      waitDone(2, 120);
      chk(16'(n > hold), 16'h0001);
      chk({st[2].doneFlag, lvl[2]}, 2'b10);
      chk(16'(len[2]), 16'(`BTP_SEMI_PULSE_CYC));
      clr(2);
    end
    for (k = 0; k < 2; k++) begin
      semiGo <= 1'b1;
      tick(1);
      semiGo <= 1'b0;
      waitOe(3, 1'b1);
      tick($urandom_range(5, 40));
      chk(oe[3], 1'b1);
      ready <= 10'h008;
      tick(1);
      ready <= 10'h000;
      waitOe(3, 1'b0);
      tick(2);
      chk(st[3].doneFlag, 1'b1);
      clr(3);
    end
    for (k = 0; k < 3; k++) begin
      ackDly <= 8'($urandom_range(1, 20));
      go(4);
      waitDone(4, 80);
      tick(4);
      chk(st[4].doneFlag, 1'b1);
      chk(16'(len[4] > ackDly), 16'h0001);
      clr(4);
    end
    for (k = 0; k < 2; k++) begin
      cfg[8].accRising <= k == 0;
      m = $urandom_range(2, 5);
      a0 = acc;
      repeat (m) begin
        syncDrv <= 1'b1;
        tick(3);
        syncDrv <= 1'b0;
        tick(6);
      end
      tick(8);
      chk(16'(acc - a0), 16'(m));
    end
    chk({st[8].riseFlag, st[8].fallFlag, st[8].irqReq}, 3'b111);
    clr(8);
    {cfg[8].irqRiseEn, cfg[8].irqFallEn} <= 2'b00;
    tick(3);
    chk({st[8].riseFlag, st[8].fallFlag, st[8].irqReq}, 3'b000);
    syncDrv <= 1'b1;
    tick(3);
    syncDrv <= 1'b0;
    tick(10);
    chk({st[8].riseFlag, st[8].fallFlag, st[8].irqReq}, 3'b110);
    clr(8);
    runLevel <= 10'h040;
    waitOe(6, 1'b1);
    runLevel <= 10'h000;
    waitOe(6, 1'b0);
    for (k = 0; k < 2; k++) begin
      clkMode <= btp_clk_mode_t'(k[0]);
      tick(3);
      chk({refOe, extOe}, {k[0], ~k[0]});
    end
    frontIn <= 1'b1;
    waitOe(9, 1'b1);
    frontIn <= 1'b0;
    waitOe(9, 1'b0);
    // Both reference paths copy a 10-cycle clock: 7 and 5 high per period.
    hold = 0;
    a0 = 0;
    repeat (20) begin
      tick(1);
      hold += refOut;
      a0 += extOut;
    end
    chk(16'(hold), 16'h000E);
    chk(16'(a0), 16'h000A);
    // The far side sources an asynchronous transfer on line 8 to line 9.
    cfg[9] <= '{MODE_ASYNC_ACC, ROUTE_NONE, 1'b0, 1'b0, 1'b0};
    tick(2);
    syncDrv <= 1'b1;
    tick(8);
    chk(st[9].busy, 1'b1);
    chk(oe[9], 1'b0);
    ready <= 10'h200;
    tick(1);
    ready <= 10'h000;
    waitOe(9, 1'b1);
    syncDrv <= 1'b0;
    waitOe(9, 1'b0);
    tick(2);
    chk(st[9].doneFlag, 1'b1);
    wrap_up;
  end
endmodule
